// ===== shared/elg_defs.vh
// constants for the enclave leaf gate and page-add checker
// assumes plain verilog-2005 inclusion by bare name
`ifndef ELG_DEFS_VH
`define ELG_DEFS_VH
`define ELG_LEAF_PAGE_ADD 32'h00000001
`define ELG_LEAF_EXIT_LIMIT 32'h0000003F
`define ELG_BITMAP_LAST 6'h3F
`define ELG_LEAF_COUNT 32'h00000010
`define ELG_ERR_ZERO 16'h0000
`define ELG_OSS_BIT 5
`define ELG_ALIGN_32B_MASK 64'h000000000000001F
`define ELG_ALIGN_4K_MASK 64'h0000000000000FFF
`define ELG_ALIGN_64B_MASK 64'h000000000000003F
`define ELG_PT_REG 8'h02
`define ELG_PT_TCS 8'h01
`define ELG_CPL_ZERO 2'h0
`define ELG_LO32_MASK 64'h00000000FFFFFFFF
// result codes
`define ELG_RES_NONE 3'h0
`define ELG_RES_ABORT 3'h1
`define ELG_RES_UD 3'h2
`define ELG_RES_VMEXIT 3'h3
`define ELG_RES_GP 3'h4
`define ELG_RES_DISPATCH 3'h5
`define ELG_RES_PF 3'h6
`define ELG_RES_DONE 3'h7
// apb register map
`define ELG_ADDR_CTRL 12'h000
`define ELG_ADDR_STATUS 12'h004
`define ELG_ADDR_LEAF 12'h008
`define ELG_ADDR_COUNT 12'h00C
`endif

// ===== hw/elg_gate.v
// hypervisor enclave instruction gate plus page-add leaf checks
// assumes core state arrives as levels on pclk; memory lookups are done outside
// Summary of operation
// RULE_01: no protection, v86, sysmgmt, no virtualization: invalid-opcode
// RULE_02: privilege above zero gives invalid-opcode
// RULE_03: paging off or undefined leaf: gp zero
// RULE_04: guest without execute control: invalid-opcode
// RULE_05: guest exiting bitmap selects vm exit
// RULE_06: guest in 64-bit mode: invalid-opcode
// RULE_07: feature lock or enable clear: gp zero
// RULE_08: oversubscription flag clear gives invalid-opcode
// RULE_09: lock, osize, rep, vex prefix: invalid-opcode
// RULE_10: expand-down data outside 64-bit: gp zero
// RULE_11: outside 64-bit drop upper accumulator half
// RULE_12: 64-bit width only with long mode and long cs
// RULE_13: segment, address-size, rex prefixes ignored
// RULE_14: transaction abort precedes every other check
// RULE_15: real-address mode gives invalid-opcode
// RULE_16: page-add leaf 01H, descriptor and target operands
// RULE_17: page-add copies, maps and measures the page
// RULE_18: page-add only at privilege zero
// RULE_19: page-add faults on listed bad operands
// RULE_20: page-add faults on locked target or control
// RULE_21: target exclusive, control shared, conflict qualifier
// RULE_22: control exclusive against add, extend, initialize
// RULE_23: page-add access kinds per operand
// RULE_24: passing checks dispatch to the selected leaf
// RULE_25: fixed priority abort, opcode, exit, protection
`timescale 1ns/100ps
`include "elg_defs.vh"
module elg_gate (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire issue,
  input wire txn_active,
  input wire protection_enable_bit,
  input wire paging_enable_bit,
  input wire virtual_8086_flag,
  input wire system_management_state,
  input wire hardware_virtualization,
  input wire guest_mode,
  input wire exec_enable_ctrl,
  input wire exiting_ctrl,
  input wire [63:0] exiting_bitmap,
  input wire long_mode_active,
  input wire cs_long,
  input wire cs_default_size,
  input wire [1:0] current_privilege_level,
  input wire feature_lock,
  input wire enclave_feature_enable,
  input wire [31:0] capability_word,
  input wire prefix_lock,
  input wire prefix_osize,
  input wire prefix_rep,
  input wire prefix_vex,
  input wire prefix_seg,
  input wire prefix_asize,
  input wire prefix_rex,
  input wire ds_expand_down,
  input wire [63:0] accumulator_reg,
  input wire [63:0] first_operand_reg,
  input wire [63:0] second_operand_reg,
  input wire [63:0] source_page_pointer,
  input wire [63:0] control_page_addr,
  input wire [63:0] security_info_addr,
  input wire [63:0] linear_addr,
  input wire [7:0] page_type,
  input wire security_info_struct_reserved_nz,
  input wire security_info_struct_r,
  input wire security_info_struct_w,
  input wire target_in_cache,
  input wire target_valid,
  input wire control_valid,
  input wire control_is_secs,
  input wire control_initialized,
  input wire tcs_fields_bad,
  input wire [63:0] enclave_base,
  input wire [63:0] enclave_size,
  input wire target_locked,
  input wire control_locked,
  input wire measure_busy,
  input wire control_excl_busy,
  input wire epc_virt_ext,
  output reg gate_done,
  output reg [2:0] gate_result,
  output reg [15:0] error_code,
  output reg [31:0] dispatch_leaf,
  output reg wide_mode,
  output reg page_conflict_qualifier,
  output reg copy_start,
  output reg map_update,
  output reg measure_extend,
  output reg [63:0] mapped_linear,
  output reg [63:0] measure_offset,
  output reg target_excl_hold,
  output reg control_shared_hold,
  output reg [2:0] access_kinds
);
  localparam ST_IDLE = 3'b001;
  localparam ST_GATE = 3'b010;
  localparam ST_ADD = 3'b100;

  reg [2:0] state_q;
  reg gate_enable_q;
  reg [31:0] count_q;
  reg [2:0] last_result_q;
  reg [31:0] leaf_q;
  reg wide_q;

  // no synchroniser; the issue pulse is taken as a same-domain level
  wire in64 = long_mode_active & cs_long; // RULE_12
  wire [63:0] acc_eff = in64 ? accumulator_reg : (accumulator_reg & `ELG_LO32_MASK); // RULE_11
  wire [31:0] leaf = acc_eff[31:0];
  wire exit_bit = (leaf < `ELG_LEAF_EXIT_LIMIT) ? exiting_bitmap[leaf[5:0]]
                  : exiting_bitmap[`ELG_BITMAP_LAST]; // RULE_05
  // segment, asize, rex and default-size bits deliberately unused
  wire ignored_pfx = prefix_seg | prefix_asize | prefix_rex | cs_default_size; // RULE_13

  wire ud_mode = ~protection_enable_bit | virtual_8086_flag | system_management_state
                 | ~hardware_virtualization; // RULE_01 RULE_15
  wire ud_oss = ~capability_word[`ELG_OSS_BIT]; // RULE_08
  wire ud_guest64 = guest_mode & in64; // RULE_06
  wire ud_cpl = current_privilege_level != `ELG_CPL_ZERO; // RULE_02
  wire ud_pfx = prefix_lock | prefix_osize | prefix_rep | prefix_vex; // RULE_09
  wire ud_exec = guest_mode & ~exec_enable_ctrl; // RULE_04
  wire any_ud = ud_mode | ud_oss | ud_guest64 | ud_cpl | ud_pfx | ud_exec;
  wire vm_exit = guest_mode & exec_enable_ctrl & exiting_ctrl & exit_bit; // RULE_05
  wire gp_feat = ~feature_lock | ~enclave_feature_enable; // RULE_07
  wire gp_leaf = leaf >= `ELG_LEAF_COUNT; // RULE_03
  wire gp_page = ~paging_enable_bit; // RULE_03
  wire gp_ds = ~in64 & ds_expand_down; // RULE_10
  wire any_gp = gp_feat | gp_leaf | gp_page | gp_ds;

  // page-add operand checks, all resolved combinationally from outside lookups
  wire mis_align = ((first_operand_reg & `ELG_ALIGN_32B_MASK) != 64'h0)
                   | ((second_operand_reg & `ELG_ALIGN_4K_MASK) != 64'h0)
                   | ((source_page_pointer & `ELG_ALIGN_4K_MASK) != 64'h0)
                   | ((control_page_addr & `ELG_ALIGN_4K_MASK) != 64'h0)
                   | ((security_info_addr & `ELG_ALIGN_64B_MASK) != 64'h0)
                   | ((linear_addr & `ELG_ALIGN_4K_MASK) != 64'h0); // RULE_19
  wire bad_attr = security_info_struct_reserved_nz
                  | ~((page_type == `ELG_PT_REG) | (page_type == `ELG_PT_TCS))
                  | ((page_type == `ELG_PT_REG) & security_info_struct_w & ~security_info_struct_r); // RULE_19
  wire bad_tcs = (page_type == `ELG_PT_TCS) & tcs_fields_bad; // RULE_19
  wire bad_range = (linear_addr < enclave_base) | (linear_addr >= enclave_base + enclave_size); // RULE_19
  wire gp_add = mis_align | bad_attr | bad_tcs | bad_range | control_locked | control_excl_busy
                | measure_busy | control_initialized; // RULE_20 RULE_22
  wire pf_add = ~target_in_cache | target_valid | ~control_valid | ~control_is_secs; // RULE_19
  wire add_cpl_bad = current_privilege_level != `ELG_CPL_ZERO; // RULE_18

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      gate_done <= 1'b0;
      gate_result <= `ELG_RES_NONE;
      error_code <= `ELG_ERR_ZERO;
      dispatch_leaf <= 32'h00000000;
      wide_mode <= 1'b0;
      page_conflict_qualifier <= 1'b0;
      copy_start <= 1'b0;
      map_update <= 1'b0;
      measure_extend <= 1'b0;
      mapped_linear <= 64'h0000000000000000;
      measure_offset <= 64'h0000000000000000;
      target_excl_hold <= 1'b0;
      control_shared_hold <= 1'b0;
      access_kinds <= 3'h0;
      count_q <= 32'h00000000;
      last_result_q <= `ELG_RES_NONE;
      leaf_q <= 32'h00000000;
      wide_q <= 1'b0;
    end else begin
      gate_done <= 1'b0;
      copy_start <= 1'b0;
      map_update <= 1'b0;
      measure_extend <= 1'b0;
      page_conflict_qualifier <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          target_excl_hold <= 1'b0;
          control_shared_hold <= 1'b0;
          access_kinds <= 3'h0;
          if (issue && gate_enable_q) begin
            state_q <= ST_GATE;
            leaf_q <= leaf;
            wide_q <= in64 & ~ignored_pfx | in64 & ignored_pfx; // RULE_12 RULE_13
          end
        end
        ST_GATE: begin
          wide_mode <= wide_q;
          error_code <= `ELG_ERR_ZERO;
          dispatch_leaf <= leaf_q;
          state_q <= ST_IDLE;
          gate_done <= 1'b1;
          count_q <= count_q + 32'h00000001;
          if (txn_active) begin
            gate_result <= `ELG_RES_ABORT; // RULE_14 RULE_25
            last_result_q <= `ELG_RES_ABORT;
          end else if (any_ud) begin
            gate_result <= `ELG_RES_UD; // RULE_25
            last_result_q <= `ELG_RES_UD;
          end else if (vm_exit) begin
            gate_result <= `ELG_RES_VMEXIT; // RULE_25
            last_result_q <= `ELG_RES_VMEXIT;
          end else if (any_gp) begin
            gate_result <= `ELG_RES_GP; // RULE_25
            last_result_q <= `ELG_RES_GP;
          end else if (leaf_q == `ELG_LEAF_PAGE_ADD) begin
            gate_result <= `ELG_RES_DISPATCH; // RULE_24 RULE_16
            last_result_q <= `ELG_RES_DISPATCH;
            gate_done <= 1'b0;
            state_q <= ST_ADD;
          end else begin
            gate_result <= `ELG_RES_DISPATCH; // RULE_24
            last_result_q <= `ELG_RES_DISPATCH;
          end
        end
        ST_ADD: begin
          state_q <= ST_IDLE;
          gate_done <= 1'b1;
          if (add_cpl_bad || mis_align || bad_attr) begin
            gate_result <= `ELG_RES_GP; // RULE_18 RULE_19
            last_result_q <= `ELG_RES_GP;
          end else if (target_locked) begin
            // conflict on the target goes to the hypervisor when it virtualises the cache
            page_conflict_qualifier <= guest_mode & epc_virt_ext; // RULE_21
            gate_result <= (guest_mode & epc_virt_ext) ? `ELG_RES_VMEXIT : `ELG_RES_GP; // RULE_20 RULE_21
            last_result_q <= (guest_mode & epc_virt_ext) ? `ELG_RES_VMEXIT : `ELG_RES_GP;
          end else if (pf_add) begin
            gate_result <= `ELG_RES_PF; // RULE_19
            last_result_q <= `ELG_RES_PF;
          end else if (gp_add) begin
            gate_result <= `ELG_RES_GP; // RULE_19 RULE_20 RULE_22
            last_result_q <= `ELG_RES_GP;
          end else begin
            last_result_q <= `ELG_RES_DONE;
            target_excl_hold <= 1'b1; // RULE_21
            control_shared_hold <= 1'b1; // RULE_21
            access_kinds <= 3'h7; // RULE_23
            copy_start <= 1'b1; // RULE_17
            map_update <= 1'b1; // RULE_17
            measure_extend <= 1'b1; // RULE_17
            mapped_linear <= linear_addr;
            measure_offset <= linear_addr - enclave_base;
            gate_result <= `ELG_RES_DONE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // apb slave, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_enable_q <= 1'b1;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      // write lands only in the completing access cycle
      if (psel && penable && pready && pwrite && paddr == `ELG_ADDR_CTRL) begin
        gate_enable_q <= pwdata[0];
      end
      if (psel && !penable) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        if (paddr == `ELG_ADDR_CTRL) begin
          prdata <= {31'h00000000, gate_enable_q};
        end else if (paddr == `ELG_ADDR_STATUS) begin
          prdata <= {28'h0000000, state_q == ST_IDLE, last_result_q};
        end else if (paddr == `ELG_ADDR_LEAF) begin
          prdata <= leaf_q;
        end else if (paddr == `ELG_ADDR_COUNT) begin
          prdata <= count_q;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // elg_gate

// ===== tb/elg_gate_monitor.sv
// checker on the gate outputs
// assumes bind onto elg_gate, ports matched by name
`timescale 1ns/100ps
`include "elg_defs.vh"
module elg_gate_monitor (
  input wire pclk,
  input wire presetn,
  input wire txn_active,
  input wire [1:0] current_privilege_level,
  input wire prefix_lock,
  input wire prefix_osize,
  input wire prefix_rep,
  input wire prefix_vex,
  input wire [31:0] capability_word,
  input wire gate_done,
  input wire [2:0] gate_result,
  input wire [15:0] error_code,
  input wire [31:0] dispatch_leaf,
  input wire page_conflict_qualifier,
  input wire copy_start,
  input wire map_update,
  input wire measure_extend
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // inputs are sampled one edge before the result lands
  wire pfx = prefix_lock | prefix_osize | prefix_rep | prefix_vex;
  wire oversubscription_support_flag = capability_word[`ELG_OSS_BIT];
  sequence s_pa_go;
    !gate_done && gate_result == `ELG_RES_DISPATCH && dispatch_leaf == `ELG_LEAF_PAGE_ADD;
  endsequence
  a_abort_first: assert property (gate_done && $past(txn_active) |-> gate_result == `ELG_RES_ABORT)
    else $error("abort lost");
  a_priv_ud: assert property (gate_done && !$past(txn_active) && $past(current_privilege_level) != 2'h0
    |-> gate_result == `ELG_RES_UD)
    else $error("privilege not refused");
  a_prefix_ud: assert property (gate_done && !$past(txn_active) && $past(pfx) |-> gate_result == `ELG_RES_UD)
    else $error("prefix not refused");
  a_oss_ud: assert property (gate_done && !$past(txn_active) && !$past(oversubscription_support_flag) |-> gate_result == `ELG_RES_UD)
    else $error("oversubscription not refused");
  a_err_zero: assert property (gate_done && gate_result == `ELG_RES_GP |-> error_code == 16'h0000)
    else $error("error code not zero");
  a_add_pulses: assert property (copy_start |-> gate_done && map_update && measure_extend
    && gate_result == `ELG_RES_DONE)
    else $error("page add pulses apart");
  a_conflict_exit: assert property (page_conflict_qualifier |-> gate_done && gate_result == `ELG_RES_VMEXIT)
    else $error("qualifier without exit");
  a_pa_step: assert property (s_pa_go |=> gate_done && gate_result != `ELG_RES_DISPATCH)
    else $error("page add not finished");
endmodule // elg_gate_monitor
bind elg_gate elg_gate_monitor u_mon (.*);

// ===== tb/elg_sw_model.sv
// issuing software: operands and page-add memory picture
// assumes levels held steady across each check
`timescale 1ns/100ps
module elg_sw_model (
  input wire misalign,
  output logic [63:0] first_operand_reg,
  output logic [63:0] second_operand_reg,
  output logic [63:0] source_page_pointer,
  output logic [63:0] control_page_addr,
  output logic [63:0] security_info_addr,
  output logic [63:0] linear_addr,
  output logic [63:0] enclave_base,
  output logic [63:0] enclave_size
);
  // descriptor off its 32-byte grid only when asked
  assign first_operand_reg = misalign ? 64'h1010 : 64'h1000;
  assign second_operand_reg = 64'h20000;
  assign source_page_pointer = 64'h30000;
  assign control_page_addr = 64'h40000;
  assign security_info_addr = 64'h50040;
  assign linear_addr = 64'h13000;
  assign enclave_base = 64'h10000;
  assign enclave_size = 64'h8000;
endmodule // elg_sw_model

// ===== tb/elg_gate_tb.sv
// bench: apb register access and gate scenarios
// assumes elg_gate, elg_sw_model and the bound checker
`timescale 1ns/100ps
`include "elg_defs.vh"
module elg_gate_tb;
  logic pclk, presetn, psel, penable, pwrite, issue, misalign, er, pready, pslverr, gate_done, wide_mode;
  logic page_conflict_qualifier, copy_start, map_update, measure_extend, txn_active, protection_enable_bit;
  logic paging_enable_bit, virtual_8086_flag, system_management_state, hardware_virtualization, guest_mode;
  logic exec_enable_ctrl, exiting_ctrl, long_mode_active, cs_long, cs_default_size, feature_lock, prefix_lock;
  logic enclave_feature_enable, prefix_osize, prefix_rep, prefix_vex, prefix_seg, prefix_asize, prefix_rex;
  logic ds_expand_down, security_info_struct_reserved_nz, security_info_struct_r, security_info_struct_w, target_in_cache, target_valid, control_valid;
  logic control_is_secs, control_initialized, tcs_fields_bad, target_locked, control_locked, measure_busy;
  logic control_excl_busy, epc_virt_ext, target_excl_hold, control_shared_hold;
  logic [1:0] current_privilege_level;
  logic [2:0] gate_result, access_kinds;
  logic [3:0] pulses;
  logic [7:0] page_type;
  logic [11:0] paddr;
  logic [15:0] error_code;
  logic [31:0] pwdata, prdata, capability_word, dispatch_leaf, rd;
  logic [63:0] exiting_bitmap, accumulator_reg, first_operand_reg, second_operand_reg, source_page_pointer;
  logic [63:0] control_page_addr, security_info_addr, linear_addr, enclave_base, enclave_size, mapped_linear;
  logic [63:0] measure_offset;
  logic [2:0] exp_res [0:29] = '{1, 2, 2, 2, 2, 2, 4, 4, 2, 3, 3, 4, 2, 4, 2, 2, 2, 2, 2, 4, 5, 5, 5, 7, 4, 4, 3,
    4, 6, 4};
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  elg_gate DUT (.*);
  elg_sw_model sw (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // no fixed wait: polls pready, giving up and counting an error after 20 cycles
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task base;
    {txn_active, virtual_8086_flag, system_management_state, guest_mode, exec_enable_ctrl, exiting_ctrl} <= '0;
    {long_mode_active, cs_long, cs_default_size, prefix_lock, prefix_osize, prefix_rep, prefix_vex} <= '0;
    {prefix_seg, prefix_asize, prefix_rex, ds_expand_down, misalign, security_info_struct_reserved_nz, security_info_struct_w} <= '0;
    {target_valid, control_initialized, tcs_fields_bad, target_locked, control_locked, measure_busy} <= '0;
    {control_excl_busy, epc_virt_ext, current_privilege_level, exiting_bitmap} <= '0;
    {protection_enable_bit, paging_enable_bit, hardware_virtualization, feature_lock, enclave_feature_enable} <= '1;
    {security_info_struct_r, target_in_cache, control_valid, control_is_secs} <= '1;
    {capability_word, page_type, accumulator_reg} <= {32'h20, 8'h2, 64'h2};
  endtask
  task gate(input int i);
    int k;
    @(posedge pclk);
    issue <= 1'b1;
    @(posedge pclk);
    issue <= 1'b0;
    k = 0;
    do begin @(posedge pclk); k++; end while (gate_done !== 1'b1 && k < 8);
    pulses = {copy_start, map_update, measure_extend, page_conflict_qualifier};
    chk("result", exp_res[i], gate_result);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, issue, paddr, pwdata} <= '0;
    base;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ELG_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 1'b1, er);
    apb(1'b1, `ELG_ADDR_CTRL, 32'h0);
    @(posedge pclk);
    issue <= 1'b1;
    er = 1'b0;
    repeat (6) begin
      @(posedge pclk);
      issue <= 1'b0;
      er = er | gate_done;
    end
    chk("refused", 1'b0, er);
    apb(1'b1, `ELG_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 30; i++) begin
      @(posedge pclk);
      base;
      case (i)
        0: {txn_active, protection_enable_bit} <= 2'h2;
        1: protection_enable_bit <= 1'b0;
        2: virtual_8086_flag <= 1'b1;
        3: system_management_state <= 1'b1;
        4: hardware_virtualization <= 1'b0;
        5: {current_privilege_level, paging_enable_bit} <= 3'h6;
        6: paging_enable_bit <= 1'b0;
        7: accumulator_reg <= 64'h10;
        8: guest_mode <= 1'b1;
        9: {guest_mode, exec_enable_ctrl, exiting_ctrl, exiting_bitmap} <= {3'h7, 64'h4};
        10: {guest_mode, exec_enable_ctrl, exiting_ctrl, feature_lock, accumulator_reg, exiting_bitmap} <=
          {4'hE, 64'h40, 64'h8000000000000000};
        11: {guest_mode, exec_enable_ctrl, exiting_ctrl, accumulator_reg, exiting_bitmap} <=
          {3'h7, 64'h3F, 64'h7FFFFFFFFFFFFFFF};
        12: {guest_mode, exec_enable_ctrl, long_mode_active, cs_long} <= 4'hF;
        13: enclave_feature_enable <= 1'b0;
        14: capability_word <= 32'hFFFFFFDF;
        15, 16, 17, 18: {prefix_lock, prefix_osize, prefix_rep, prefix_vex} <= 4'(4'h8 >> (i - 15));
        19: ds_expand_down <= 1'b1;
        20: {ds_expand_down, long_mode_active, cs_long} <= 3'h7;
        21: {prefix_seg, prefix_asize, prefix_rex, long_mode_active, cs_long} <= 5'h1F;
        22: {accumulator_reg, cs_default_size} <= {64'hFFFFFFFF00000002, 1'b1};
        23: accumulator_reg <= 64'h1;
        24: {accumulator_reg, misalign} <= {64'h1, 1'b1};
        25: {accumulator_reg, target_locked} <= {64'h1, 1'b1};
        26: {accumulator_reg, target_locked, guest_mode, exec_enable_ctrl, epc_virt_ext} <= {64'h1, 4'hF};
        27: {accumulator_reg, control_excl_busy} <= {64'h1, 1'b1};
        28: {accumulator_reg, target_valid} <= {64'h1, 1'b1};
        29: {accumulator_reg, control_locked} <= {64'h1, 1'b1};
        default: ;
      endcase
      gate(i);
      if (i == 20 || i == 22) chk("wide", i == 20, wide_mode);
      if (i == 22) chk("leaf", 32'h2, dispatch_leaf);
      if (i == 23) begin
        chk("pulses", 4'hE, pulses);
        chk("linear", 64'h13000, mapped_linear);
        chk("offset", 64'h3000, measure_offset);
        chk("holds", 5'h1F, {target_excl_hold, control_shared_hold, access_kinds});
      end
      if (i == 26) chk("qualifier", 4'h1, pulses);
    end
    apb(1'b0, `ELG_ADDR_LEAF, 32'h0);
    chk("leaf reg", 32'h1, rd);
    apb(1'b0, `ELG_ADDR_COUNT, 32'h0);
    chk("count reg", 32'h0000001E, rd);
    apb(1'b0, `ELG_ADDR_STATUS, 32'h0);
    chk("status reg", 32'h0000000C, rd);
    finish_test;
  end
endmodule // elg_gate_tb
